// ---- hw/psm_monitor.sv ----
// Top of the printer sensor monitor: cover, toner, stacker and cassette size
//
// Functional notes
// - Cover switch off raises cover-open notice
// - Long magnet encounter means low-toner sample
// - Toner low set after two low samples
// - Toner low cleared after two full samples
// - Alarm if toner sensor unchanged two cycles
// - Toner monitoring frozen while drum stopped
// - Stacker-full sensor raises stacker-full inhibit
// - Latch size switches on cassette insertion
// - Decode switch patterns to paper sizes
`timescale 1ns/10ps
module psm_monitor #(
    parameter longint LONG_ENC  = longint'(psm_pkg::LONG_ENC_DFLT),
    parameter longint STUCK_CYC = psm_pkg::STUCK_CYC_DFLT
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               cover_switch_on,
    input  wire logic               toner_magnet,
    input  wire logic               drum_running,
    input  wire logic               stacker_full_sensor,
    input  wire logic               cassette_present,
    input  wire logic               size_switch_first,
    input  wire logic               size_switch_second,
    input  wire logic               size_switch_third,
    input  wire logic               size_switch_fourth,
    output logic                    cover_open_notice,
    output logic                    toner_low,
    output logic                    toner_sensor_alarm,
    output logic                    stacker_full,
    output logic                    size_valid,
    output psm_pkg::psm_size_t      size_code
);

    // ****************************************************************
    // Size decode
    // ****************************************************************
    function automatic psm_pkg::psm_size_t decode_size(input logic [3:0] sw);
        psm_pkg::psm_size_t r;
        r = psm_pkg::PSM_SIZE_UNKNOWN;
        case (sw)
            psm_pkg::SW_LETTER:    r = psm_pkg::PSM_SIZE_LETTER;
            psm_pkg::SW_EXECUTIVE: r = psm_pkg::PSM_SIZE_EXECUTIVE;
            psm_pkg::SW_A4:        r = psm_pkg::PSM_SIZE_A4;
            psm_pkg::SW_LEGAL14:   r = psm_pkg::PSM_SIZE_LEGAL14;
            psm_pkg::SW_LEGAL13:   r = psm_pkg::PSM_SIZE_LEGAL13;
            psm_pkg::SW_B5:        r = psm_pkg::PSM_SIZE_B5;
            psm_pkg::SW_A5:        r = psm_pkg::PSM_SIZE_A5;
            psm_pkg::SW_A6:        r = psm_pkg::PSM_SIZE_A6_UNSUPPORTED;
            default:               r = psm_pkg::PSM_SIZE_UNKNOWN;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // Toner sampling
    // ****************************************************************
    psm_toner_if toner_bus ();

    psm_toner_sampler #(
        .LONG_ENC  (LONG_ENC),
        .STUCK_CYC (STUCK_CYC)
    ) u_sampler (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .toner_magnet (toner_magnet),
        .drum_running (drum_running),
        .smp          (toner_bus)
    );

    // ****************************************************************
    // Status registers
    // ****************************************************************
    // Every status output comes from a flop so the control logic never
    // sees a glitch from a bouncing switch within one clock.
    logic       cover_open_q;
    logic       stacker_full_q;
    logic       toner_low_q;
    logic [1:0] run_cnt_q;
    logic       present_q;
    logic       size_valid_q;
    psm_pkg::psm_size_t size_q;

    // ****************************************************************
    // Cover and stacker
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cover_open_q   <= 1'b0;
            stacker_full_q <= 1'b0;
        end else begin
            cover_open_q   <= !cover_switch_on;
            stacker_full_q <= stacker_full_sensor;
        end
    end

    // ****************************************************************
    // Toner low debounce
    // ****************************************************************
    // Counts consecutive samples that disagree with the current status;
    // a sample that agrees breaks the run, so single outliers never flip it.
    // Samples only arrive with the drum turning; a halt keeps the run count,
    // so a run may straddle a stop and still complete after it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            toner_low_q <= 1'b0;
            run_cnt_q   <= '0;
        end else if (drum_running && toner_bus.sample_valid) begin
            if (toner_bus.sample_low == toner_low_q) begin
                run_cnt_q <= '0;
            end else if (run_cnt_q + 2'(1) >= 2'(psm_pkg::DEBOUNCE_COUNT)) begin
                toner_low_q <= toner_bus.sample_low;
                run_cnt_q   <= '0;
            end else begin
                run_cnt_q <= run_cnt_q + 2'(1);
            end
        end
    end

    // ****************************************************************
    // Cassette size latch
    // ****************************************************************
    // The switches are read once, on insertion; later tab movement with
    // the cassette seated is ignored. A cassette already seated when reset
    // ends looks like a fresh insertion and is latched on the first edge.
    // Removal drops the code back to unknown so a stale size never stands.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            present_q    <= 1'b0;
            size_valid_q <= 1'b0;
            size_q       <= psm_pkg::PSM_SIZE_UNKNOWN;
        end else begin
            present_q <= cassette_present;
            if (cassette_present && !present_q) begin
                size_valid_q <= 1'b1;
                size_q       <= decode_size({size_switch_first, size_switch_second,
                                             size_switch_third, size_switch_fourth});
            end else if (!cassette_present) begin
                size_valid_q <= 1'b0;
                size_q       <= psm_pkg::PSM_SIZE_UNKNOWN;
            end
        end
    end

    // ****************************************************************
    // Output drive
    // ****************************************************************
    // Plain wiring only: no logic may sit between the flops and the pins.
    assign cover_open_notice  = cover_open_q;
    assign stacker_full       = stacker_full_q;
    assign toner_low          = toner_low_q;
    assign toner_sensor_alarm = toner_bus.stuck;
    assign size_valid         = size_valid_q;
    assign size_code          = size_q;
endmodule

// ---- pkg/psm_pkg.sv ----
// Package of constants and types for the printer sensor monitor
package psm_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned SENSE_CYCLE_US  = 2_727_000;   // 2.727 s sensing cycle
    localparam longint     SENSE_CYCLE_CYC  = longint'(SENSE_CYCLE_US) * longint'(CLK_HZ / 1_000_000);
    localparam int unsigned STUCK_CYCLES    = 2;           // Cycles without change before alarm
    localparam longint     STUCK_CYC_DFLT   = SENSE_CYCLE_CYC * longint'(STUCK_CYCLES);
    localparam int unsigned LONG_ENC_DFLT   = 1_000_000;   // Long-encounter threshold, in clocks
    localparam int unsigned DEBOUNCE_COUNT  = 2;           // Consecutive samples to change status
    localparam int unsigned CNT_W           = 40;

    // ****************************************************************
    // Cassette size codes
    // ****************************************************************
    typedef enum logic [3:0] {
        PSM_SIZE_UNKNOWN,
        PSM_SIZE_LETTER,
        PSM_SIZE_EXECUTIVE,
        PSM_SIZE_A4,
        PSM_SIZE_LEGAL14,
        PSM_SIZE_LEGAL13,
        PSM_SIZE_B5,
        PSM_SIZE_A5,
        PSM_SIZE_A6_UNSUPPORTED
    } psm_size_t;

    // Switch patterns, first switch in bit 3
    localparam logic [3:0] SW_LETTER    = 4'h7;
    localparam logic [3:0] SW_EXECUTIVE = 4'h5;
    localparam logic [3:0] SW_A4        = 4'h3;
    localparam logic [3:0] SW_LEGAL14   = 4'he;
    localparam logic [3:0] SW_LEGAL13   = 4'hb;
    localparam logic [3:0] SW_B5        = 4'hd;
    localparam logic [3:0] SW_A5        = 4'hc;
    localparam logic [3:0] SW_A6        = 4'h9;

endpackage

// ---- pkg/psm_toner_if.sv ----
// Interface carrying toner samples from the classifier to the monitor core
`timescale 1ns/10ps
interface psm_toner_if;
    logic sample_valid;
    logic sample_low;
    logic stuck;

    modport src (
        output sample_valid,
        output sample_low,
        output stuck
    );
    modport dst (
        input  sample_valid,
        input  sample_low,
        input  stuck
    );
endinterface

// ---- hw/psm_toner_sampler.sv ----
// Toner sensor encounter timing, sample classification and stuck detection
`timescale 1ns/10ps
module psm_toner_sampler #(
    parameter longint LONG_ENC  = longint'(psm_pkg::LONG_ENC_DFLT),
    parameter longint STUCK_CYC = psm_pkg::STUCK_CYC_DFLT
) (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    input  wire logic  toner_magnet,
    input  wire logic  drum_running,
    psm_toner_if.src   smp
);
    localparam int W = psm_pkg::CNT_W;

    logic         magnet_q;
    logic [W-1:0] enc_cnt_q;
    logic [W-1:0] idle_cnt_q;
    logic         valid_q;
    logic         low_q;
    logic         stuck_q;

    wire change = toner_magnet != magnet_q;

    // Last seen level; held while the drum stands so a halt looks like no change
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            magnet_q <= 1'b0;
        end else if (drum_running) begin
            magnet_q <= toner_magnet;
        end
    end

    // Encounter length: counted while magnet seen, classified on its release
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enc_cnt_q <= '0;
            valid_q   <= 1'b0;
            low_q     <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (drum_running) begin
                if (toner_magnet && !magnet_q) begin
                    enc_cnt_q <= W'(1);
                end else if (toner_magnet && enc_cnt_q != '1) begin
                    enc_cnt_q <= enc_cnt_q + W'(1);
                end else if (!toner_magnet && magnet_q) begin
                    valid_q <= 1'b1;
                    low_q   <= enc_cnt_q >= W'(LONG_ENC);
                end
            end
        end
    end

    // Stuck sensor: no edge for the full alarm time; clears on the next edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            idle_cnt_q <= '0;
            stuck_q    <= 1'b0;
        end else if (drum_running) begin
            if (change) begin
                idle_cnt_q <= '0;
                stuck_q    <= 1'b0;
            end else if (idle_cnt_q >= W'(STUCK_CYC) - W'(1)) begin
                stuck_q <= 1'b1;
            end else begin
                idle_cnt_q <= idle_cnt_q + W'(1);
            end
        end
    end

    assign smp.sample_valid = valid_q;
    assign smp.sample_low   = low_q;
    assign smp.stuck        = stuck_q;
endmodule

// ---- tb/psm_monitor_props.sv ----
// Port-level assertions for the printer sensor monitor
`timescale 1ns/10ps
module psm_monitor_props #(
    parameter longint STUCK_CYC = 50
) (
    input wire logic               ref_clk,
    input wire logic               rst,
    input wire logic               cover_switch_on,
    input wire logic               toner_magnet,
    input wire logic               drum_running,
    input wire logic               stacker_full_sensor,
    input wire logic               cassette_present,
    input wire logic               cover_open_notice,
    input wire logic               toner_low,
    input wire logic               toner_sensor_alarm,
    input wire logic               stacker_full,
    input wire logic               size_valid,
    input wire psm_pkg::psm_size_t size_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Running edges without a magnet change; tolerance of 3 covers the pipeline
    logic [15:0] still_q;
    logic        last_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            still_q <= 16'h0000;
            last_q  <= 1'b0;
        end else if (drum_running) begin
            last_q  <= toner_magnet;
            still_q <= (toner_magnet != last_q) ? 16'h0000 : still_q + {15'h0000, ~&still_q};
        end
    end
    chk_cover_follow: assert property (1'b1 |=> cover_open_notice == !$past(cover_switch_on))
        else $error("cover notice wrong");
    chk_stacker_follow: assert property (1'b1 |=> stacker_full == $past(stacker_full_sensor))
        else $error("stacker full wrong");
    chk_size_rise: assert property ($rose(cassette_present) |=> size_valid)
        else $error("size not valid");
    chk_size_gone: assert property (!cassette_present |=> !size_valid)
        else $error("size valid without cassette");
    chk_size_hold: assert property (size_valid && cassette_present |=> $stable(size_code))
        else $error("size code moved");
    chk_halt_freeze: assert property (!drum_running [*3] |=> $stable(toner_low) && $stable(toner_sensor_alarm))
        else $error("toner status moved in halt");
    chk_alarm_clear: assert property (drum_running && $changed(toner_magnet) ##1 drum_running |=> !toner_sensor_alarm)
        else $error("alarm stands after change");
    chk_alarm_late: assert property (still_q > STUCK_CYC + 3 |-> toner_sensor_alarm)
        else $error("alarm missing");
    chk_alarm_early: assert property ($rose(toner_sensor_alarm) |-> still_q + 3 >= STUCK_CYC)
        else $error("alarm too early");
endmodule

// ---- tb/psm_sensors.sv ----
// Behavioural toner sensor: one magnet encounter of commanded length, then a quiet gap
`timescale 1ns/10ps
module psm_sensors (
    input  wire logic       ref_clk,
    input  wire logic       pulse_req,
    input  wire logic [7:0] pulse_len,
    output logic            toner_magnet,
    output logic            busy
);
    int cnt = 0;
    initial toner_magnet = 1'b0;
    initial busy = 1'b0;
    always @(posedge ref_clk) begin
        if (!busy && pulse_req) begin
            busy         <= 1'b1;
            cnt          <= pulse_len + 6;
            toner_magnet <= 1'b1;
        end else if (busy) begin
            cnt          <= cnt - 1;
            toner_magnet <= (cnt > 7);
            busy         <= (cnt != 1);
        end
    end
endmodule

// ---- tb/tb_psm_monitor.sv ----
// Self-checking bench for the printer sensor monitor
`timescale 1ns/10ps
module tb_psm_monitor;
    localparam longint LONG_ENC  = 10;
    localparam longint STUCK_CYC = 50;
    logic               ref_clk  = 1'b0;
    logic               rst      = 1'b1;
    logic               cover_sw = 1'b1;
    logic               drum     = 1'b1;
    logic               stk_in   = 1'b0;
    logic               cas      = 1'b0;
    logic               req      = 1'b0;
    logic [3:0]         sw       = 4'h0;
    logic [7:0]         plen     = 8'h01;
    logic               magnet, busy, cov_o, low_o, alm_o, stk_o, val_o;
    psm_pkg::psm_size_t code_o;
    int                 num_errors = 0;
    int                 n_checks   = 0;
    int                 seed       = 32'h4ebcadc3;
    int                 run        = 0;
    logic               exp_low    = 1'b0;
    int                 corner[8]  = '{9, 10, 10, 9, 9, 10, 1, 10};

    always #2.5 ref_clk = ~ref_clk;

    psm_sensors u_sens (.ref_clk(ref_clk), .pulse_req(req), .pulse_len(plen), .toner_magnet(magnet), .busy(busy));
    psm_monitor #(.LONG_ENC(LONG_ENC), .STUCK_CYC(STUCK_CYC)) uut (
        .ref_clk(ref_clk), .rst(rst), .cover_switch_on(cover_sw), .toner_magnet(magnet), .drum_running(drum),
        .stacker_full_sensor(stk_in), .cassette_present(cas), .size_switch_first(sw[3]),
        .size_switch_second(sw[2]), .size_switch_third(sw[1]), .size_switch_fourth(sw[0]),
        .cover_open_notice(cov_o), .toner_low(low_o), .toner_sensor_alarm(alm_o), .stacker_full(stk_o),
        .size_valid(val_o), .size_code(code_o));

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Codes in the order of the size enum; unlisted patterns are unknown
    function automatic logic [3:0] exp_size(input logic [3:0] p);
        case (p)
            4'h7: return 4'h1;
            4'h5: return 4'h2;
            4'h3: return 4'h3;
            4'he: return 4'h4;
            4'hb: return 4'h5;
            4'hd: return 4'h6;
            4'hc: return 4'h7;
            4'h9: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction

    // Request held until the sensor model acknowledges with busy
    task automatic toner_sample(input int len);
        int i;
        if (drum) begin
            run = ((len >= LONG_ENC) == exp_low) ? 0 : run + 1;
            if (run == 2) begin
                exp_low = ~exp_low;
                run = 0;
            end
        end
        @(negedge ref_clk);
        plen = len[7:0];
        req = 1'b1;
        for (i = 0; i < 50 && busy !== 1'b1; i++) @(negedge ref_clk);
        if (busy !== 1'b1) begin
            num_errors++;
            test_done();
        end
        req = 1'b0;
        for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge ref_clk);
        if (busy !== 1'b0) begin
            num_errors++;
            test_done();
        end
        chk(low_o, exp_low);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        repeat (8) begin
            @(negedge ref_clk);
            {cover_sw, stk_in} = 2'($random(seed));
            @(negedge ref_clk);
            chk(cov_o, !cover_sw);
            chk(stk_o, stk_in);
        end
        for (int p = 0; p < 16; p++) begin
            @(negedge ref_clk);
            sw = 4'(p);
            cas = 1'b1;
            @(negedge ref_clk);
            sw = ~sw;
            chk(val_o, 1'b1);
            chk(code_o, exp_size(~sw));
            @(negedge ref_clk);
            chk(code_o, exp_size(~sw));
            cas = 1'b0;
            @(negedge ref_clk);
            chk(val_o, 1'b0);
        end
        foreach (corner[k]) toner_sample(corner[k]);
        repeat (24) toner_sample(1 + int'($unsigned($random(seed)) % 20));
        @(negedge ref_clk);
        drum = 1'b0;
        toner_sample(14);
        toner_sample(14);
        repeat (STUCK_CYC + 10) @(negedge ref_clk);
        chk(alm_o, 1'b0);
        drum = 1'b1;
        repeat (STUCK_CYC + 10) @(negedge ref_clk);
        chk(alm_o, 1'b1);
        toner_sample(4);
        chk(alm_o, 1'b0);
        test_done();
    end

    initial begin
        #100000;
        num_errors++;
        test_done();
    end
endmodule

bind psm_monitor psm_monitor_props #(.STUCK_CYC(STUCK_CYC)) u_props (
    .ref_clk(ref_clk), .rst(rst), .cover_switch_on(cover_switch_on), .toner_magnet(toner_magnet),
    .drum_running(drum_running), .stacker_full_sensor(stacker_full_sensor), .cassette_present(cassette_present),
    .cover_open_notice(cover_open_notice), .toner_low(toner_low), .toner_sensor_alarm(toner_sensor_alarm),
    .stacker_full(stacker_full), .size_valid(size_valid), .size_code(size_code));
